// ==== core/arfem_top.sv ====
// result table with three views, control register and external mux pins
// assumes bus, command and conversion inputs share core_clk;
// only the address pins arrive from outside and are synchronised
`timescale 1ns/10ps

// Function
// - signed view: sign at bit 15, nine magnitude bits at 14 to 6
// - raw half scale reads zero; raw at or above half scale clears sign
// - raw full scale reads 0x7FC0 in the signed view
// - raw zero reads 0x8000 in the signed view, most negative value
// - unsigned left view: raw result in bits 15 to 6, low six zero
// - register port takes byte and half-word reads and writes, 16-bit data
// - one result per read; conversions keep updating other entries meanwhile
// - external mux mode follows the mux select bit of control zero
// - in mux mode the address outputs follow each command channel
// - mux mode decodes channel to one of four expanded inputs
// - in mux mode address pins are outputs only, ignoring direction bits
// - eight internal channels; with muxes 9, 12, 15 or 18 total
// - unsigned right view: raw result in bits 9 to 0, upper zero
// - 64-entry 10-bit table written when a conversion completes
module arfem_top #(
	parameter int NUM_EXT_MUX = 4,
	parameter int ENTRIES = 64
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [1:0] regByteEn,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	output logic regRdValid,
	input wire logic convDone,
	input wire logic [5:0] convEntry,
	input wire logic [9:0] convResult,
	input wire logic cmdValid,
	input wire logic [5:0] cmdChannel,
	input wire logic [1:0] portDirBits,
	input wire logic [1:0] portOutData,
	input wire logic [1:0] addrPinIn,
	output logic [1:0] expanderAddrOut,
	output logic [1:0] expanderAddrOe,
	output logic [1:0] addrPinDigitalIn,
	output logic muxModeActive,
	output logic [2:0] convertInputSel,
	output logic convertInputValid,
	output logic [4:0] availChannels
);
	logic [9:0] resTable [ENTRIES];
	logic [9:0] next_resTable [ENTRIES];
	logic muxSel;
	logic next_muxSel;
	logic [15:0] next_regRdata;
	logic next_regRdValid;
	logic [1:0] pinMeta;
	logic [1:0] pinSync;
	logic [1:0] next_digIn;
	logic [1:0] next_addrOut;
	logic [2:0] next_inSel;
	logic next_inValid;
	logic [1:0] win;
	logic [5:0] idx;
	logic [9:0] rawSel;
	logic [15:0] viewRight;
	logic [15:0] viewSigned;
	logic [15:0] viewLeft;
	logic [15:0] viewSel;
	logic [15:0] merged;
	logic [1:0] decAddr;
	logic [2:0] decSel;
	logic decValid;

	assign win = regAddr[7:6];
	assign idx = regAddr[5:0];
	assign rawSel = resTable[idx];
	assign muxModeActive = muxSel;

	// one stored entry feeds every view, so no per-format storage
	assign viewRight = {6'h00, rawSel};
	// inverting the msb turns offset binary into two's complement
	assign viewSigned = {~rawSel[9], rawSel[8:0], 6'h00};
	assign viewLeft = {rawSel, 6'h00};

	// view for the addressed window; unmapped control slots read zero
	always_comb begin
		viewSel = 16'h0000;
		unique case (win)
			arfem_pkg::WIN_RIGHT_U: viewSel = viewRight;
			arfem_pkg::WIN_LEFT_S: viewSel = viewSigned;
			arfem_pkg::WIN_LEFT_U: viewSel = viewLeft;
			arfem_pkg::WIN_CTRL: begin
				if (idx == arfem_pkg::CTRL0_IDX) begin
					viewSel[arfem_pkg::CTRL0_MUX_BIT] = muxSel;
				end
			end
		endcase
	end

	// byte lanes merge into the current view before write-back
	always_comb begin
		merged = viewSel;
		if (regByteEn[0]) begin
			merged[7:0] = regWdata[7:0];
		end
		if (regByteEn[1]) begin
			merged[15:8] = regWdata[15:8];
		end
	end

	// result table: bus writes, then conversions, so hardware wins a tie
	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			next_resTable[i] = resTable[i];
		end
		if (regWrite && win != arfem_pkg::WIN_CTRL) begin
			unique case (win)
				arfem_pkg::WIN_RIGHT_U: next_resTable[idx] = merged[9:0];
				arfem_pkg::WIN_LEFT_S:
					next_resTable[idx] = {~merged[15], merged[14:6]};
				default: next_resTable[idx] = merged[15:6];
			endcase
		end
		if (convDone) begin
			// other entries keep updating while software reads
			next_resTable[convEntry] = convResult;
		end
	end

	// table flops; no reset needed on data, but cleared for determinism
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < ENTRIES; i++) begin
				resTable[i] <= 10'(arfem_pkg::RES_RST);
			end
		end else begin
			for (int i = 0; i < ENTRIES; i++) begin
				resTable[i] <= next_resTable[i];
			end
		end
	end

	// control zero and read answer, one result per read
	always_comb begin
		next_muxSel = muxSel;
		if (regWrite && win == arfem_pkg::WIN_CTRL &&
				idx == arfem_pkg::CTRL0_IDX && regByteEn[0]) begin
			next_muxSel = regWdata[arfem_pkg::CTRL0_MUX_BIT];
		end
		next_regRdValid = regRead;
		next_regRdata = regRead ? viewSel : regRdata;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			muxSel <= arfem_pkg::CTRL0_MUX_RST;
			regRdata <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			muxSel <= next_muxSel;
			regRdata <= next_regRdata;
			regRdValid <= next_regRdValid;
		end
	end

	arfem_ch_decode #(
		.NUM_EXT_MUX(NUM_EXT_MUX)
	) u_decode (
		.channel(cmdChannel),
		.muxMode(muxSel),
		.expanderAddr(decAddr),
		.inputSel(decSel),
		.inputValid(decValid)
	);

	// pin data: address from each command in mux mode, port data otherwise
	always_comb begin
		next_addrOut = expanderAddrOut;
		next_inSel = convertInputSel;
		next_inValid = convertInputValid;
		if (!muxSel) begin
			next_addrOut = portOutData;
		end else if (cmdValid) begin
			next_addrOut = decAddr;
		end
		if (cmdValid) begin
			next_inSel = decSel;
			next_inValid = decValid;
		end
		// address pins give no digital input while they drive the mux
		next_digIn = muxSel ? 2'h0 : pinSync;
	end

	// pins are asynchronous, so two flops before anything reads them
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinMeta <= 2'h0;
			pinSync <= 2'h0;
			addrPinDigitalIn <= 2'h0;
			expanderAddrOut <= 2'h0;
			convertInputSel <= 3'h0;
			convertInputValid <= 1'b0;
		end else begin
			pinMeta <= addrPinIn;
			pinSync <= pinMeta;
			addrPinDigitalIn <= next_digIn;
			expanderAddrOut <= next_addrOut;
			convertInputSel <= next_inSel;
			convertInputValid <= next_inValid;
		end
	end

	// direction bits only count outside mux mode
	assign expanderAddrOe = muxSel ? 2'h3 : portDirBits;

	// usable channel count: 6 - n direct plus 4n expanded, or 8 direct
	assign availChannels = muxSel ? 5'(6 + 3 * NUM_EXT_MUX) :
		5'(arfem_pkg::INT_INPUTS);

	property p_signed_view;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_S |=>
			regRdValid && regRdata == {~$past(rawSel[9]),
			$past(rawSel[8:0]), 6'h00};
	endproperty
	a_signed_view: assert property (p_signed_view)
		else $error("signed view mismatch");

	property p_half_scale;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_S &&
			rawSel >= arfem_pkg::HALF_SCALE |=> !regRdata[15];
	endproperty
	a_half_scale: assert property (p_half_scale)
		else $error("sign set for value above half scale");

	property p_full_scale;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_S && rawSel == 10'h3ff
			|=> regRdata == 16'h7fc0;
	endproperty
	a_full_scale: assert property (p_full_scale)
		else $error("full scale not 0x7fc0");

	property p_zero_scale;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_S && rawSel == 10'h000
			|=> regRdata == 16'h8000;
	endproperty
	a_zero_scale: assert property (p_zero_scale)
		else $error("zero not 0x8000");

	property p_left_view;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_U |=>
			regRdata[15:6] == $past(rawSel) && regRdata[5:0] == 6'h00;
	endproperty
	a_left_view: assert property (p_left_view)
		else $error("unsigned left view mismatch");

	property p_right_view;
		@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_RIGHT_U |=>
			regRdata == {6'h00, $past(rawSel)};
	endproperty
	a_right_view: assert property (p_right_view)
		else $error("right view mismatch");

	property p_conv_store;
		@(posedge core_clk) disable iff (rst)
		convDone |=> resTable[$past(convEntry)] == $past(convResult);
	endproperty
	a_conv_store: assert property (p_conv_store)
		else $error("conversion result not stored");

	property p_mux_addr;
		@(posedge core_clk) disable iff (rst)
		muxSel && cmdValid |=> expanderAddrOut == $past(cmdChannel[2:1]);
	endproperty
	a_mux_addr: assert property (p_mux_addr)
		else $error("mux address not from channel");

	property p_pins_output;
		@(posedge core_clk) disable iff (rst)
		muxSel |-> expanderAddrOe == 2'h3 ##1
			(!muxSel || addrPinDigitalIn == 2'h0);
	endproperty
	a_pins_output: assert property (p_pins_output)
		else $error("address pins not outputs only");

	property p_mux_mode;
		@(posedge core_clk) disable iff (rst)
		regWrite && win == arfem_pkg::WIN_CTRL && idx == 6'h00 &&
			regByteEn[0] |=> muxModeActive == $past(regWdata[7]);
	endproperty
	a_mux_mode: assert property (p_mux_mode)
		else $error("mux mode not following control bit");

	property p_ext_input;
		@(posedge core_clk) disable iff (rst)
		muxSel && cmdValid && !cmdChannel[5] && !cmdChannel[3] |=>
			convertInputSel == {1'b0, $past(cmdChannel[4]),
			$past(cmdChannel[0])};
	endproperty
	a_ext_input: assert property (p_ext_input)
		else $error("expanded input decode wrong");

	c_signed_read: cover property (@(posedge core_clk) disable iff (rst)
		regRead && win == arfem_pkg::WIN_LEFT_S ##1 regRdValid);
	c_byte_write: cover property (@(posedge core_clk) disable iff (rst)
		regWrite && regByteEn == 2'h1);
	c_mux_cmd: cover property (@(posedge core_clk) disable iff (rst)
		muxSel && cmdValid);
	c_conv_read: cover property (@(posedge core_clk) disable iff (rst)
		convDone && regRead);
endmodule : arfem_top

// ==== core/arfem_pkg.sv ====
// constants shared by the result-format and external-mux logic
// assumes one clock domain and a half-word-indexed register port
package arfem_pkg;
	// result table geometry
	localparam int RES_W = 10;
	localparam int ENTRY_W = 6;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int CHAN_W = 6;
	// address windows, selected by the two top address bits
	localparam logic [1:0] WIN_RIGHT_U = 2'h0;
	localparam logic [1:0] WIN_LEFT_S = 2'h1;
	localparam logic [1:0] WIN_LEFT_U = 2'h2;
	localparam logic [1:0] WIN_CTRL = 2'h3;
	// index of converter_control_zero inside the control window
	localparam logic [5:0] CTRL0_IDX = 6'h00;
	// external-mux select bit inside converter_control_zero
	localparam int CTRL0_MUX_BIT = 7;
	localparam logic CTRL0_MUX_RST = 1'b0;
	// field positions of the result views
	localparam int SIGN_BIT = 15;
	localparam int LEFT_LSB = 6;
	localparam int RES_RST = 0;
	// half scale of the raw result
	localparam logic [9:0] HALF_SCALE = 10'h200;
	// channel numbers of the direct inputs; only A and B share the address port pins
	localparam logic [5:0] CH_DIR_A = 6'h34;
	localparam logic [5:0] CH_DIR_B = 6'h35;
	localparam logic [5:0] CH_DIR_C = 6'h37;
	localparam logic [5:0] CH_DIR_D = 6'h38;
	// internal multiplexer size and external mux limits
	localparam int INT_INPUTS = 8;
	localparam int MAX_EXT_MUX = 4;
	localparam int EXT_INPUTS = 4;
endpackage : arfem_pkg

// ==== core/arfem_ch_decode.sv ====
// channel decode for the converter front end
// assumes the channel comes from the command word being executed
`timescale 1ns/10ps
module arfem_ch_decode #(
	parameter int NUM_EXT_MUX = 4
) (
	input wire logic [5:0] channel,
	input wire logic muxMode,
	output logic [1:0] expanderAddr,
	output logic [2:0] inputSel,
	output logic inputValid
);
	logic [1:0] extIdx;

	// mux address always follows channel bits 2 and 1
	assign expanderAddr = channel[2:1];
	assign extIdx = {channel[4], channel[0]};

	// pick the internal input; pins 52 and 53 are lost in mux mode
	always_comb begin
		inputSel = 3'h0;
		inputValid = 1'b0;
		if (channel == arfem_pkg::CH_DIR_C) begin
			inputSel = 3'h6;
			inputValid = 1'b1;
		end else if (channel == arfem_pkg::CH_DIR_D) begin
			inputSel = 3'h7;
			inputValid = 1'b1;
		end else if (muxMode) begin
			// expanded inputs sit on internal inputs 0 to 3
			if (!channel[5] && !channel[3]) begin
				inputSel = {1'b0, extIdx};
				inputValid = (32'(extIdx) < NUM_EXT_MUX);
			end
		end else if (channel[5:2] == 4'h0) begin
			inputSel = {1'b0, channel[1:0]};
			inputValid = 1'b1;
		end else if (channel == arfem_pkg::CH_DIR_A) begin
			inputSel = 3'h4;
			inputValid = 1'b1;
		end else if (channel == arfem_pkg::CH_DIR_B) begin
			inputSel = 3'h5;
			inputValid = 1'b1;
		end
	end
endmodule : arfem_ch_decode

// ==== verification/arfem_ext_mux_model.sv ====
// far side: external mux chips on the shared address lines and a
// digital source that owns the pins whenever the converter lets go
`timescale 1ns/10ps
module arfem_ext_mux_model (
	input wire logic [1:0] addrOut,
	input wire logic [1:0] addrOe,
	input wire logic [1:0] extDrive,
	output logic [1:0] pinLevel,
	output logic [1:0] muxSelect
);
	// each pin resolves from whoever holds its enable; the source backs
	// off while the converter drives, so there is never contention
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			pinLevel[b] = addrOe[b] ? addrOut[b] : extDrive[b];
		end
	end
	// every fitted chip decodes the same two address lines
	assign muxSelect = pinLevel;
endmodule : arfem_ext_mux_model

// ==== verification/adc_result_format_extmux_tb.sv ====
// self-checking bench for the result views and the external mux pins
// assumes arfem_pkg and the design modules are compiled first
`timescale 1ns/10ps
module adc_result_format_extmux_tb;
	localparam int NMUX = 3;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic regRead = 1'b0;
	logic regWrite = 1'b0;
	logic [1:0] regByteEn = 2'h0;
	logic [15:0] regWdata = 16'h0000;
	logic convDone = 1'b0;
	logic [5:0] convEntry = 6'h00;
	logic [9:0] convResult = 10'h000;
	logic cmdValid = 1'b0;
	logic [5:0] cmdChannel = 6'h00;
	logic [1:0] portDirBits = 2'h0;
	logic [1:0] portOutData = 2'h0;
	logic [1:0] extDrive = 2'h0;
	logic [15:0] regRdata;
	logic regRdValid, muxModeActive, inValid;
	logic [1:0] pinLevel, addrOut, addrOe, pinIn, muxSel;
	logic [2:0] inSel;
	logic [4:0] avail;
	logic [9:0] r;
	logic [5:0] ch;
	logic [15:0] expQ[$];
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;

	always #10 core_clk = ~core_clk;

	arfem_top #(.NUM_EXT_MUX(NMUX), .ENTRIES(64)) dut (
		.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
		.regRead(regRead), .regWrite(regWrite), .regByteEn(regByteEn),
		.regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
		.convDone(convDone), .convEntry(convEntry),
		.convResult(convResult), .cmdValid(cmdValid),
		.cmdChannel(cmdChannel), .portDirBits(portDirBits),
		.portOutData(portOutData), .addrPinIn(pinLevel),
		.expanderAddrOut(addrOut), .expanderAddrOe(addrOe),
		.addrPinDigitalIn(pinIn), .muxModeActive(muxModeActive),
		.convertInputSel(inSel), .convertInputValid(inValid),
		.availChannels(avail));

	arfem_ext_mux_model far (.addrOut(addrOut), .addrOe(addrOe),
		.extDrive(extDrive), .pinLevel(pinLevel), .muxSelect(muxSel));

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	// read request; the answer is compared by the watcher below
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		expQ.push_back(exp);
		@(posedge core_clk);
		regRead <= 1'b0;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [1:0] be,
		input logic [15:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regByteEn <= be;
		regWdata <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic conv(input logic [5:0] e, input logic [9:0] v);
		@(posedge core_clk);
		convDone <= 1'b1;
		convEntry <= e;
		convResult <= v;
		@(posedge core_clk);
		convDone <= 1'b0;
	endtask : conv

	// issue one command, then look once its registered outputs settle
	task automatic cmd(input logic [5:0] c);
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdChannel <= c;
		@(posedge core_clk);
		cmdValid <= 1'b0;
		@(negedge core_clk);
	endtask : cmd

	// read data stands one cycle, so it is taken off mid-cycle
	always @(negedge core_clk) begin
		if (regRdValid === 1'b1) begin
			if (expQ.size() == 0) begin
				check("unexpected read", regRdata, 16'hxxxx);
			end else begin
				check("regRdata", regRdata, expQ.pop_front());
			end
		end
	end

	// hang guard, well above the fewer than two hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(59757));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check("availChannels", 16'(avail), 16'h0008);
		// boundary raw values first, then random ones, in all views
		for (int i = 0; i < 8; i++) begin
			r = (i == 0) ? 10'h200 : (i == 1) ? 10'h3ff :
				(i == 2) ? 10'h000 : 10'($urandom);
			conv(6'(i * 9), r);
			rd({arfem_pkg::WIN_LEFT_S, 6'(i * 9)},
				{~r[9], r[8:0], 6'h00});
			rd({arfem_pkg::WIN_LEFT_U, 6'(i * 9)}, {r, 6'h00});
			rd({arfem_pkg::WIN_RIGHT_U, 6'(i * 9)}, {6'h00, r});
		end
		// half-word and byte writes through each view
		wr({arfem_pkg::WIN_LEFT_U, 6'h05}, 2'h3, 16'hffc0);
		rd({arfem_pkg::WIN_RIGHT_U, 6'h05}, 16'h03ff);
		wr({arfem_pkg::WIN_RIGHT_U, 6'h05}, 2'h1, 16'hff12);
		rd({arfem_pkg::WIN_RIGHT_U, 6'h05}, 16'h0312);
		wr({arfem_pkg::WIN_LEFT_S, 6'h05}, 2'h2, 16'h0000);
		rd({arfem_pkg::WIN_RIGHT_U, 6'h05}, 16'h0202);
		// a read and a conversion elsewhere in the same cycle
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= {arfem_pkg::WIN_RIGHT_U, 6'h05};
		convDone <= 1'b1;
		convEntry <= 6'h06;
		convResult <= 10'h155;
		expQ.push_back(16'h0202);
		@(posedge core_clk);
		regRead <= 1'b0;
		convDone <= 1'b0;
		rd({arfem_pkg::WIN_RIGHT_U, 6'h06}, 16'h0155);
		// outside mux mode the pins are plain port bits
		portDirBits <= 2'($urandom);
		portOutData <= 2'($urandom);
		extDrive <= 2'($urandom);
		cmd(6'h02);
		repeat (4) @(negedge core_clk);
		check("expanderAddrOe", 16'(addrOe), 16'(portDirBits));
		check("expanderAddrOut", 16'(addrOut), 16'(portOutData));
		check("addrPinDigitalIn", 16'(pinIn), 16'(pinLevel));
		check("convertInputSel", 16'(inSel), 16'h0002);
		// shared port pins and special channels outside mux mode
		cmd(6'h34);
		check("convertInputSel", 16'(inSel), 16'h0004);
		cmd(6'h38);
		check("convertInputSel", 16'(inSel), 16'h0007);
		cmd(6'h3c);
		check("convertInputValid", 16'(inValid), 16'h0000);
		// enter mux mode with every direction bit low
		@(posedge core_clk);
		portDirBits <= 2'h0;
		wr({arfem_pkg::WIN_CTRL, arfem_pkg::CTRL0_IDX}, 2'h1, 16'h0080);
		rd({arfem_pkg::WIN_CTRL, arfem_pkg::CTRL0_IDX}, 16'h0080);
		rd({arfem_pkg::WIN_CTRL, 6'h01}, 16'h0000);
		@(negedge core_clk);
		check("muxModeActive", 16'(muxModeActive), 16'h0001);
		check("availChannels", 16'(avail), 16'(6 + 3 * NMUX));
		check("expanderAddrOe", 16'(addrOe), 16'h0003);
		for (int c = 0; c < 24; c++) begin
			ch = 6'(c);
			if (ch[3] == 1'b0) begin
				cmd(ch);
				check("expanderAddrOut", 16'(addrOut), 16'(ch[2:1]));
				check("muxSelect", 16'(muxSel), 16'(ch[2:1]));
				check("convertInputSel", 16'(inSel),
					16'({ch[4], ch[0]}));
				check("convertInputValid", 16'(inValid),
					16'(int'({ch[4], ch[0]}) < NMUX));
				check("addrPinDigitalIn", 16'(pinIn), 16'h0000);
			end
		end
		cmd(6'h37);
		check("convertInputSel", 16'(inSel), 16'h0006);
		// the address pins give up their analog inputs in mux mode
		cmd(6'h34);
		check("convertInputValid", 16'(inValid), 16'h0000);
		// leaving mux mode restores the direct channel count
		wr({arfem_pkg::WIN_CTRL, arfem_pkg::CTRL0_IDX}, 2'h3, 16'h0000);
		@(negedge core_clk);
		check("muxModeActive", 16'(muxModeActive), 16'h0000);
		check("availChannels", 16'(avail), 16'h0008);
		repeat (3) @(posedge core_clk);
		check("pending reads", 16'(expQ.size()), 16'h0000);
		finish_test();
	end
endmodule : adc_result_format_extmux_tb
